// file: hdl/dprp_pkg.sv
// Purpose: Shared constants and types for the dual-port reservation panel
// Assumes: 100 MHz clock, single domain
// Notes: Switch positions are one-hot pins, debounced before use
package dprp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DEBOUNCE_US = 5000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned SYNC_STAGES = 3;
  localparam logic VARIANT_HOLD = 1'b0;
  localparam logic VARIANT_PRIO = 1'b1;

  typedef enum logic [1:0] {
    DPRP_SW_AUTO,
    DPRP_SW_RES_A,
    DPRP_SW_RES_B
  } dprp_sw_t;

  typedef enum logic [1:0] {
    DPRP_OWN_NONE,
    DPRP_OWN_A,
    DPRP_OWN_B
  } dprp_own_t;

  // Per-port request signals from the adaptor path
  typedef struct packed {
    logic sel_req;
    logic sel_done;
    logic release_req;
    logic prio_claim;
    logic active;
  } dprp_port_req_t;

  // Per-port status back to the adaptor path
  typedef struct packed {
    logic granted;
    logic pending;
    logic peer_holds_drive_status;
    logic peer_has_drive_status;
  } dprp_port_sts_t;
endpackage

// file: hdl/dprp_debounce.sv
// Purpose: Three-flop synchroniser and stability filter for one pin
// Assumes: Pin is asynchronous to clk_i
// Notes: Output changes only after the pin holds steady for CNT_CYC cycles
`timescale 1ns/1ps
module dprp_debounce import dprp_pkg::*; #(
  parameter int unsigned CNT_CYC = DEBOUNCE_CYC
) (
  input wire logic clk_i, // System clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic pin_i, // Raw pin level
  input wire logic rst_val_i, // Level taken while in reset (constant tie)
  output logic level_o // Filtered level
);
  localparam int unsigned CW = $clog2(CNT_CYC + 1);
  logic [SYNC_STAGES-1:0] sync_ff;
  logic [CW-1:0] cnt_ff;
  logic level_ff;

  // Stage 1 feeds only stage 2; stages 2 and 3 are compared
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= {sync_ff[SYNC_STAGES-2:0], pin_i};
    end
  end

  // Count steady cycles of an agreed level that differs from the output
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      level_ff <= rst_val_i;
    end else if ((sync_ff[1] == sync_ff[2]) && (sync_ff[2] != level_ff)) begin
      if (cnt_ff >= CW'(CNT_CYC - 1)) begin
        cnt_ff <= '0;
        level_ff <= sync_ff[2];
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end else begin
      cnt_ff <= '0;
    end
  end

  assign level_o = level_ff;
endmodule

// file: hdl/dprp_panel.sv
// Purpose: Reservation override and panel indicators of a dual-port adaptor
// Assumes: Port request inputs come from logic on clk_i; switch pins are raw
// Notes: Ownership is one of none, A, B; the manual switch overrides it
`timescale 1ns/1ps
module dprp_panel import dprp_pkg::*; #(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC, // Switch filter length
  parameter logic VARIANT = VARIANT_HOLD // Cable variant
) (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic sw_res_a_i, // Switch contact for reserve A, raw pin
  input wire logic sw_res_b_i, // Switch contact for reserve B, raw pin
  input wire dprp_port_req_t req_a_i, // Port A requests
  input wire dprp_port_req_t req_b_i, // Port B requests
  output dprp_port_sts_t sts_a_o, // Port A status
  output dprp_port_sts_t sts_b_o, // Port B status
  output dprp_own_t owner_o, // Current drive owner
  output logic forced_o, // Manual override in effect
  output logic lamp_res_a_o, // Port A reserve lamp
  output logic lamp_res_b_o, // Port B reserve lamp
  output logic lamp_act_a_o, // Port A activity lamp
  output logic lamp_act_b_o // Port B activity lamp
);
  logic deb_a, deb_b;
  dprp_sw_t sw_pos;
  dprp_own_t own_ff, nxt_own;
  logic win_b_ff; // Pending winner: 0 means A, 1 means B
  logic busy_ff; // A selection attempt is in flight
  logic last_b_ff; // Alternating tie-break
  logic frc_int_ff; // Switch forced, in step with own_ff
  dprp_port_sts_t sts_a_ff, sts_b_ff;
  logic res_a_ff, res_b_ff, act_a_ff, act_b_ff, forced_ff;
  dprp_own_t owner_ff;

  dprp_debounce #(.CNT_CYC(DEB_CYC)) u_deb_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sw_res_a_i),
    .rst_val_i(1'b0),
    .level_o(deb_a)
  );
  dprp_debounce #(.CNT_CYC(DEB_CYC)) u_deb_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(sw_res_b_i),
    .rst_val_i(1'b0),
    .level_o(deb_b)
  );

  // Both contacts closed is a broken switch; treat it as automatic
  always_comb begin
    if (deb_a && !deb_b) begin
      sw_pos = DPRP_SW_RES_A;
    end else if (deb_b && !deb_a) begin
      sw_pos = DPRP_SW_RES_B;
    end else begin
      sw_pos = DPRP_SW_AUTO;
    end
  end

  // Release test depends on cable variant
  function automatic logic port_release(input dprp_port_req_t r);
    if (VARIANT == VARIANT_HOLD) begin
      port_release = r.release_req;
    end else begin
      port_release = !r.sel_req && !r.prio_claim;
    end
  endfunction

  // Ownership next state
  // Release acts on the level only while a port owns; from none a finished selection still takes the drive
  always_comb begin
    nxt_own = own_ff;
    case (sw_pos)
      DPRP_SW_RES_A: nxt_own = DPRP_OWN_A;
      DPRP_SW_RES_B: nxt_own = DPRP_OWN_B;
      DPRP_SW_AUTO: begin
        case (own_ff)
          DPRP_OWN_NONE: begin
            if (busy_ff && !win_b_ff && req_a_i.sel_done) begin
              nxt_own = DPRP_OWN_A;
            end else if (busy_ff && win_b_ff && req_b_i.sel_done) begin
              nxt_own = DPRP_OWN_B;
            end
          end
          DPRP_OWN_A: begin
            if (port_release(req_a_i)) begin
              nxt_own = DPRP_OWN_NONE;
            end else if (VARIANT == VARIANT_HOLD && req_b_i.release_req) begin
              nxt_own = DPRP_OWN_NONE;
            end else if (VARIANT == VARIANT_PRIO && req_b_i.prio_claim && !req_a_i.prio_claim) begin
              nxt_own = DPRP_OWN_B;
            end
          end
          DPRP_OWN_B: begin
            if (port_release(req_b_i)) begin
              nxt_own = DPRP_OWN_NONE;
            end else if (VARIANT == VARIANT_HOLD && req_a_i.release_req) begin
              nxt_own = DPRP_OWN_NONE;
            end else if (VARIANT == VARIANT_PRIO && req_a_i.prio_claim && !req_b_i.prio_claim) begin
              nxt_own = DPRP_OWN_A;
            end
          end
          default: nxt_own = DPRP_OWN_NONE;
        endcase
      end
      default: nxt_own = DPRP_OWN_NONE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      own_ff <= DPRP_OWN_NONE;
    end else begin
      own_ff <= nxt_own;
    end
  end

  // Forced flag registered beside own_ff, so forced_o and owner_o change on one edge
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frc_int_ff <= 1'b0;
    end else begin
      frc_int_ff <= (sw_pos != DPRP_SW_AUTO);
    end
  end

  // tie-break and hold loser
  // A winner that drops its select frees the arbiter; one that stalls holding its select blocks the other
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      win_b_ff <= 1'b0;
      last_b_ff <= 1'b0;
    end else if (sw_pos != DPRP_SW_AUTO || own_ff != DPRP_OWN_NONE) begin
      busy_ff <= 1'b0;
    end else if (!busy_ff) begin
      if (req_a_i.sel_req && req_b_i.sel_req) begin
        busy_ff <= 1'b1;
        win_b_ff <= !last_b_ff; // Alternate so neither port starves
        last_b_ff <= !last_b_ff;
      end else if (req_a_i.sel_req || req_b_i.sel_req) begin
        busy_ff <= 1'b1;
        win_b_ff <= req_b_i.sel_req;
        last_b_ff <= req_b_i.sel_req;
      end
    end else if ((win_b_ff ? !req_b_i.sel_req : !req_a_i.sel_req)) begin
      busy_ff <= 1'b0; // Winner dropped without completing
    end
  end

  // Port status; granted follows ownership, pending marks the held loser
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sts_a_ff <= '0;
      sts_b_ff <= '0;
    end else begin
      sts_a_ff.granted <= (own_ff == DPRP_OWN_A);
      sts_b_ff.granted <= (own_ff == DPRP_OWN_B);
      sts_a_ff.pending <= req_a_i.sel_req && busy_ff && win_b_ff;
      sts_b_ff.pending <= req_b_i.sel_req && busy_ff && !win_b_ff;
      sts_a_ff.peer_holds_drive_status <= (VARIANT == VARIANT_HOLD) && req_a_i.sel_req && (own_ff == DPRP_OWN_B);
      sts_b_ff.peer_holds_drive_status <= (VARIANT == VARIANT_HOLD) && req_b_i.sel_req && (own_ff == DPRP_OWN_A);
      sts_a_ff.peer_has_drive_status <= (VARIANT == VARIANT_PRIO) && (own_ff == DPRP_OWN_B);
      sts_b_ff.peer_has_drive_status <= (VARIANT == VARIANT_PRIO) && (own_ff == DPRP_OWN_A);
    end
  end

  // Panel lamps and mode outputs, all registered
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      res_a_ff <= 1'b0;
      res_b_ff <= 1'b0;
      act_a_ff <= 1'b0;
      act_b_ff <= 1'b0;
      forced_ff <= 1'b0;
      owner_ff <= DPRP_OWN_NONE;
    end else begin
      res_a_ff <= (req_a_i.sel_req && own_ff != DPRP_OWN_B) || own_ff == DPRP_OWN_A;
      res_b_ff <= (req_b_i.sel_req && own_ff != DPRP_OWN_A) || own_ff == DPRP_OWN_B;
      act_a_ff <= req_a_i.active && own_ff == DPRP_OWN_A;
      act_b_ff <= req_b_i.active && own_ff == DPRP_OWN_B;
      forced_ff <= frc_int_ff;
      owner_ff <= own_ff;
    end
  end

  assign sts_a_o = sts_a_ff;
  assign sts_b_o = sts_b_ff;
  assign owner_o = owner_ff;
  assign forced_o = forced_ff;
  assign lamp_res_a_o = res_a_ff;
  assign lamp_res_b_o = res_b_ff;
  assign lamp_act_a_o = act_a_ff;
  assign lamp_act_b_o = act_b_ff;
endmodule

// file: verif/dprp_panel_chk.sv
// Purpose: Port checks of the reservation panel
// Assumes: One clock, sync active-low reset
// Notes: Registered outputs lag their cause by one edge
`timescale 1ns/1ps
module dprp_panel_chk import dprp_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire dprp_port_req_t req_a_i, // A requests
  input wire dprp_port_req_t req_b_i, // B requests
  input wire dprp_port_sts_t sts_a_o, // A status
  input wire dprp_port_sts_t sts_b_o, // B status
  input wire dprp_own_t owner_o, // Owner
  input wire logic forced_o, // Override
  input wire logic lamp_res_a_o, // Lamp
  input wire logic lamp_res_b_o, // Lamp
  input wire logic lamp_act_a_o, // Lamp
  input wire logic lamp_act_b_o // Lamp
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // The $past guard keeps requests seen during reset out of the first check
  a_act_a: assert property ($past(rst_n_i) |->
    lamp_act_a_o == ($past(req_a_i.active) && owner_o == DPRP_OWN_A)) else $error("A activity lamp wrong");
  a_act_b: assert property ($past(rst_n_i) |->
    lamp_act_b_o == ($past(req_b_i.active) && owner_o == DPRP_OWN_B)) else $error("B activity lamp wrong");
  a_res_a: assert property ($past(rst_n_i) && !forced_o |->
    lamp_res_a_o == ($past(req_a_i.sel_req) && owner_o != DPRP_OWN_B || owner_o == DPRP_OWN_A))
    else $error("A reserve lamp wrong");
  a_res_b: assert property ($past(rst_n_i) && !forced_o |->
    lamp_res_b_o == ($past(req_b_i.sel_req) && owner_o != DPRP_OWN_A || owner_o == DPRP_OWN_B))
    else $error("B reserve lamp wrong");
  a_frc_own: assert property (forced_o |-> owner_o != DPRP_OWN_NONE) else $error("forced with no owner");
  a_frc_idle: assert property (forced_o && $past(forced_o) |-> !sts_a_o.pending && !sts_b_o.pending)
    else $error("arbiter busy while forced");
  a_grant_own: assert property (!(sts_a_o.granted && owner_o != DPRP_OWN_A)
    && !(sts_b_o.granted && owner_o != DPRP_OWN_B)) else $error("grant disagrees with owner");
  a_auto_latch: assert property (!forced_o && !$past(forced_o) && $past(owner_o) == DPRP_OWN_NONE
    && owner_o == DPRP_OWN_A |-> $past(req_a_i.sel_done, 2)) else $error("A owns without selection");
  c_tie: cover property (req_a_i.sel_req && req_b_i.sel_req && !forced_o);
  c_frc_b: cover property (forced_o && owner_o == DPRP_OWN_B);
  c_auto_b: cover property (!forced_o && owner_o == DPRP_OWN_B);
endmodule
bind dprp_panel dprp_panel_chk dprp_panel_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_a_i(req_a_i),
  .req_b_i(req_b_i), .sts_a_o(sts_a_o), .sts_b_o(sts_b_o), .owner_o(owner_o), .forced_o(forced_o),
  .lamp_res_a_o(lamp_res_a_o), .lamp_res_b_o(lamp_res_b_o), .lamp_act_a_o(lamp_act_a_o),
  .lamp_act_b_o(lamp_act_b_o));

// file: verif/dprp_drive_model.sv
// Purpose: Drive answering a selection on either port
// Assumes: Selection requests are levels on clk_i
// Notes: Delay is an input the bench changes mid-run, so answers come prompt or slow
`timescale 1ns/1ps
module dprp_drive_model (
  input wire logic clk_i, // Clock
  input wire logic [1:0] sel_i, // Selection, B in bit 1
  input wire logic [3:0] dly_i, // Answer delay in cycles
  output logic [1:0] done_o // Selected answer
);
  logic [3:0] cnt_ff [2];
  // Answer once the select has stood long enough; drop it with the select
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      cnt_ff[p] <= !sel_i[p] ? 4'h0 : (cnt_ff[p] == 4'hF ? 4'hF : cnt_ff[p] + 4'h1);
      done_o[p] <= sel_i[p] && cnt_ff[p] >= dly_i;
    end
  end
endmodule

// file: verif/test_dprp_panel.sv
// Purpose: Self-checking bench for the reservation panel
// Assumes: Inputs change on the falling edge
// Notes: Filter cut to 4 cycles to keep the run short
`timescale 1ns/1ps
module test_dprp_panel import dprp_pkg::*;;
  logic clk_i = 1'b0, rst_n_i = 1'b0, sw_a = 1'b0, sw_b = 1'b0;
  logic [1:0] sel = 2'h0, rel = 2'h0, act = 2'h0, done;
  logic [3:0] dly = 4'h1;
  dprp_port_sts_t sts_a_o, sts_b_o;
  dprp_own_t owner_o;
  logic forced_o, lamp_res_a_o, lamp_res_b_o, lamp_act_a_o, lamp_act_b_o;
  int num_errors = 0, samples_checked = 0;
  // Row: sw{a,b} sel{b,a} rel{b,a} act{b,a} owner forced lamps{act_b,act_a,res_b,res_a} peer_holds_b
  logic [15:0] rows [10] = '{16'h114A, 16'h2243, 16'h0400, 16'h2294, 16'h0800, 16'hA263, 16'h62B4,
    16'h0800, 16'hD14A, 16'h0400};
  always #5 clk_i = ~clk_i;
  dprp_drive_model dprp_drive_model_i (.clk_i(clk_i), .sel_i(sel), .dly_i(dly), .done_o(done));
  // Precedence claims tied low: the hold variant is under test
  dprp_panel #(.DEB_CYC(4)) dprp_panel_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .sw_res_a_i(sw_a),
    .sw_res_b_i(sw_b), .req_a_i({sel[0], done[0], rel[0], 1'b0, act[0]}),
    .req_b_i({sel[1], done[1], rel[1], 1'b0, act[1]}), .sts_a_o(sts_a_o), .sts_b_o(sts_b_o),
    .owner_o(owner_o), .forced_o(forced_o), .lamp_res_a_o(lamp_res_a_o), .lamp_res_b_o(lamp_res_b_o),
    .lamp_act_a_o(lamp_act_a_o), .lamp_act_b_o(lamp_act_b_o));
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", n, e, s);
    end
  endtask
  task automatic chko(input string n, input dprp_own_t e, input dprp_own_t s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", n, e, s);
    end
  endtask
  // Bounded wait for {forced, owner}; two more edges let the lamps settle
  task automatic wt(input logic [2:0] e);
    int i;
    for (i = 0; i < 60 && {forced_o, owner_o} !== e; i++) @(negedge clk_i);
    if (i == 60) begin
      num_errors++;
      close_out();
    end else begin
      repeat (2) @(negedge clk_i);
    end
  endtask
  initial begin
    logic [15:0] r;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    foreach (rows[k]) begin
      r = rows[k];
      {sw_a, sw_b, sel, rel, act} = r[15:8];
      wt({r[5], r[7:6]});
      chko("owner", dprp_own_t'(r[7:6]), owner_o);
      chk1("lamp_res_a", r[1], lamp_res_a_o);
      chk1("lamp_res_b", r[2], lamp_res_b_o);
      chk1("lamp_act_a", r[3], lamp_act_a_o);
      chk1("lamp_act_b", r[4], lamp_act_b_o);
      if (!r[5]) chk1("peer_holds_b", r[0], sts_b_o.peer_holds_drive_status);
      chk1("peer_has_b", 1'b0, sts_b_o.peer_has_drive_status);
    end
    dly = 4'h3;
    rel = 2'b00;
    sel = 2'b11;
    repeat (2) @(negedge clk_i);
    chk1("pending_a", 1'b1, sts_a_o.pending);
    chk1("pending_b", 1'b0, sts_b_o.pending);
    wt(3'b010);
    chko("owner", DPRP_OWN_B, owner_o);
    chk1("granted_b", 1'b1, sts_b_o.granted);
    chk1("peer_holds_a", 1'b1, sts_a_o.peer_holds_drive_status);
    rel = 2'b10;
    @(negedge clk_i);
    rel = 2'b00;
    sel = 2'b01;
    wt(3'b001);
    chko("owner", DPRP_OWN_A, owner_o);
    chk1("granted_a", 1'b1, sts_a_o.granted);
    sw_b = 1'b1;
    repeat (2) @(negedge clk_i);
    sw_b = 1'b0;
    repeat (12) @(negedge clk_i);
    chk1("forced", 1'b0, forced_o);
    sw_a = 1'b1;
    sel = 2'b10;
    rel = 2'b11;
    wt(3'b101);
    repeat (5) @(negedge clk_i);
    chko("owner", DPRP_OWN_A, owner_o);
    chk1("lamp_res_b", 1'b0, lamp_res_b_o);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chko("owner", DPRP_OWN_NONE, owner_o);
    rst_n_i = 1'b1;
    wt(3'b101);
    chk1("forced", 1'b1, forced_o);
    close_out();
  end
endmodule
